// ==== dpp_pkg.sv ====
// package: shared constants and carrier types for downstream port power
package dpp_pkg;
  // default port count and filter counter width
  localparam int NUM_PORTS = 4;
  localparam int FILT_W = 8;
  // default over-current filter time in ns, and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int OC_FILT_NS = 10000;
  localparam logic [7:0] OC_FILT_CYC_DEF =
    8'((OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // reset values
  localparam logic RST_SPLIT = 1'b0;
  localparam logic RST_OC = 1'b0;

  // per-pin driver control: pull-up enable, output enable (low drives)
  typedef struct packed {
    logic pullUpEn;
    logic outEnB;
    logic outVal;
  } dpp_pin_t;

  // per-port configuration
  typedef struct packed {
    logic pinFuncSel;
    logic separatedPortOption;
    logic chargeSupplyPresent;
  } dpp_cfg_t;
endpackage

// ==== dpp_oc_filter.sv ====
// over-current filter: a low must persist for a set number of cycles
`timescale 1ns/10ps
module dpp_oc_filter #(
  parameter int FILT_W = dpp_pkg::FILT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic powerOn,
  input wire logic senseLow,
  input wire logic [FILT_W-1:0] filtLen,
  output logic ocFlag
);
  logic [FILT_W-1:0] cnt_q, cnt_d;
  logic oc_q, oc_d;

  // count consecutive lows while powered; ramp glitches restart the count
  always_comb begin
    cnt_d = cnt_q;
    oc_d = oc_q;
    if (!powerOn || !senseLow) begin
      // a stale level here would re-raise the flag after re-enable
      cnt_d = '0;
      oc_d = 1'b0;
    end else begin
      if (cnt_q < filtLen) begin
        cnt_d = cnt_q + FILT_W'(1);
      end
      if (cnt_q + FILT_W'(1) >= filtLen) begin
        oc_d = 1'b1;
      end
    end
  end

  // filtered level only; the top module keeps the sticky copy
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= '0;
      oc_q <= dpp_pkg::RST_OC;
    end else begin
      cnt_q <= cnt_d;
      oc_q <= oc_d;
    end
  end

  assign ocFlag = oc_q;
endmodule // dpp_oc_filter

// ==== dpp_pin_drv.sv ====
// one open-drain power/sense pin: drive low for off, pull-up for on
`timescale 1ns/10ps
module dpp_pin_drv (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic powerOn,
  input wire logic pinIn,
  output dpp_pkg::dpp_pin_t pinCtl,
  output logic senseLow
);
  dpp_pkg::dpp_pin_t ctl_q, ctl_d;
  logic low_q, low_d;

  // disabled pins float with no pull-up and report nothing
  always_comb begin
    ctl_d = '{pullUpEn: 1'b0, outEnB: 1'b1, outVal: 1'b0};
    low_d = 1'b0;
    if (enable && !powerOn) begin
      ctl_d.outEnB = 1'b0;
      ctl_d.pullUpEn = 1'b0;
    end else if (enable) begin
      ctl_d.pullUpEn = 1'b1;
      low_d = !pinIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctl_q <= '{pullUpEn: 1'b0, outEnB: 1'b1, outVal: 1'b0};
      low_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      low_q <= low_d;
    end
  end

  assign pinCtl = ctl_q;
  assign senseLow = low_q;
endmodule // dpp_pin_drv

// ==== dpp_port_power.sv ====
// top: downstream port power enable and over-current sensing
`timescale 1ns/10ps
// Operation
// - combined mode: one pin per port for power enable and sense
// - power off drives the shared pin low
// - pull-up is off while the pin is driven low
// - power on releases the driver and enables the pull-up
// - a low on the pin, via hysteresis input, means over-current
// - transient lows are filtered out, e.g. during supply ramp
// - poly fuse setups use the same drive; a powered low is over-current
// - separation is per port from configuration
// - after reset every port is non-separated
// - non-separated: one pin serves both 2.0 and 3.2 portions
// - separated: primary pin for 2.0, dedicated pin for 3.2
// - per-port charging supply indication on the control pin
// - pins act only when pin-assignment configuration selects them
module dpp_port_power #(
  parameter int NUM_PORTS = dpp_pkg::NUM_PORTS,
  parameter int FILT_W = dpp_pkg::FILT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire dpp_pkg::dpp_cfg_t [NUM_PORTS-1:0] portCfg,
  input wire logic cfgLoad,
  input wire logic [NUM_PORTS-1:0] hsPowerReq,
  input wire logic [NUM_PORTS-1:0] ssPowerReq,
  input wire logic [FILT_W-1:0] ocFiltLen,
  input wire logic [NUM_PORTS-1:0] portPinIn,
  input wire logic [NUM_PORTS-1:0] ssPinIn,
  output dpp_pkg::dpp_pin_t [NUM_PORTS-1:0] portPinCtl,
  output dpp_pkg::dpp_pin_t [NUM_PORTS-1:0] ssPinCtl,
  output logic [NUM_PORTS-1:0] hsOverCurrent,
  output logic [NUM_PORTS-1:0] ssOverCurrent,
  output logic [NUM_PORTS-1:0] chargeIndicate,
  output logic [NUM_PORTS-1:0] separatedActive
);
  // latched configuration; split and function select taken on cfgLoad
  logic [NUM_PORTS-1:0] split_q, split_d;
  logic [NUM_PORTS-1:0] funcSel_q, funcSel_d;
  logic [NUM_PORTS-1:0] chg_q, chg_d;
  logic [NUM_PORTS-1:0] chgInd_q, chgInd_d;
  logic [NUM_PORTS-1:0] hsOn_q, hsOn_d;
  logic [NUM_PORTS-1:0] ssOn_q, ssOn_d;
  logic [NUM_PORTS-1:0] hsOc_q, hsOc_d;
  logic [NUM_PORTS-1:0] ssOc_q, ssOc_d;
  logic [NUM_PORTS-1:0] primOn, dedOn, primLow, dedLow;
  logic [NUM_PORTS-1:0] primFlag, dedFlag, primEn, dedEn;
  logic [FILT_W-1:0] filtLen;

  // a zero length would mean no filtering at all; fall back to default
  assign filtLen = (ocFiltLen == '0) ?
    FILT_W'(dpp_pkg::OC_FILT_CYC_DEF) : ocFiltLen;

  // configuration register group
  always_comb begin
    split_d = split_q;
    funcSel_d = funcSel_q;
    chg_d = chg_q;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (cfgLoad) begin
        split_d[i] = portCfg[i].separatedPortOption;
        funcSel_d[i] = portCfg[i].pinFuncSel;
        chg_d[i] = portCfg[i].chargeSupplyPresent;
      end
    end
    // registered so the indication leaves straight from a flop
    chgInd_d = chg_d & funcSel_d;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      split_q <= {NUM_PORTS{dpp_pkg::RST_SPLIT}};
      funcSel_q <= '0;
      chg_q <= '0;
      chgInd_q <= '0;
    end else begin
      split_q <= split_d;
      funcSel_q <= funcSel_d;
      chg_q <= chg_d;
      chgInd_q <= chgInd_d;
    end
  end

  // power routing: which pin carries which portion's power
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (split_q[i]) begin
        primOn[i] = hsPowerReq[i];
        dedOn[i] = ssPowerReq[i];
      end else begin
        // either portion asking powers the shared supply
        primOn[i] = hsPowerReq[i] | ssPowerReq[i];
        dedOn[i] = 1'b0;
      end
      primEn[i] = funcSel_q[i];
      dedEn[i] = funcSel_q[i] & split_q[i];
    end
  end

  // pin drivers and filters, one pair of pins per port
  for (genvar g = 0; g < NUM_PORTS; g++) begin : gPort
    dpp_pin_drv uPrimPin (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable(primEn[g]),
      .powerOn(primOn[g]),
      .pinIn(portPinIn[g]),
      .pinCtl(portPinCtl[g]),
      .senseLow(primLow[g])
    );
    dpp_pin_drv uDedPin (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable(dedEn[g]),
      .powerOn(dedOn[g]),
      .pinIn(ssPinIn[g]),
      .pinCtl(ssPinCtl[g]),
      .senseLow(dedLow[g])
    );
    dpp_oc_filter #(.FILT_W(FILT_W)) uPrimFilt (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .powerOn(hsOn_q[g] | (ssOn_q[g] & ~split_q[g])),
      .senseLow(primLow[g]),
      .filtLen(filtLen),
      .ocFlag(primFlag[g])
    );
    dpp_oc_filter #(.FILT_W(FILT_W)) uDedFilt (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .powerOn(ssOn_q[g] & split_q[g]),
      .senseLow(dedLow[g]),
      .filtLen(filtLen),
      .ocFlag(dedFlag[g])
    );
  end

  // sticky over-current per portion; detection wins over re-enable clear
  always_comb begin
    hsOn_d = hsPowerReq & primEn;
    ssOn_d = ssPowerReq & primEn;
    hsOc_d = hsOc_q;
    ssOc_d = ssOc_q;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (hsPowerReq[i] && !hsOn_q[i]) begin
        hsOc_d[i] = 1'b0;
      end
      if (ssPowerReq[i] && !ssOn_q[i]) begin
        ssOc_d[i] = 1'b0;
      end
      if (primFlag[i] && hsOn_q[i]) begin
        hsOc_d[i] = 1'b1;
      end
      if (split_q[i] ? dedFlag[i] : primFlag[i]) begin
        if (ssOn_q[i]) begin
          ssOc_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hsOn_q <= '0;
      ssOn_q <= '0;
      hsOc_q <= '0;
      ssOc_q <= '0;
    end else begin
      hsOn_q <= hsOn_d;
      ssOn_q <= ssOn_d;
      hsOc_q <= hsOc_d;
      ssOc_q <= ssOc_d;
    end
  end

  // status outputs straight from flip-flops
  assign hsOverCurrent = hsOc_q;
  assign ssOverCurrent = ssOc_q;
  assign chargeIndicate = chgInd_q;
  assign separatedActive = split_q;
endmodule // dpp_port_power

// ==== dpp_switch_model.sv ====
// partner model: power switches or fuse networks on the pins
`timescale 1ns/10ps
module dpp_switch_model #(
  parameter int N = 8
) (
  input wire logic clk_sys,
  input wire dpp_pkg::dpp_pin_t [N-1:0] pinCtl,
  input wire logic [N-1:0] fault,
  output logic [N-1:0] pinIn
);
  logic tgl_q = 1'b0;
  // a free pin wanders, so no stale level passes for a sense value
  always_ff @(posedge clk_sys) tgl_q <= ~tgl_q;
  // device drive wins; else the switch pulls low on a fault
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pinCtl[i].outEnB) pinIn[i] = pinCtl[i].outVal;
      else if (pinCtl[i].pullUpEn) pinIn[i] = !fault[i];
      else pinIn[i] = tgl_q;
    end
  end
endmodule // dpp_switch_model

// ==== dpp_port_power_checker.sv ====
// checker: pin drive and over-current relations
`timescale 1ns/10ps
module dpp_port_power_checker #(
  parameter int NUM_PORTS = 4,
  parameter int FILT_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cfgLoad,
  input wire logic [NUM_PORTS-1:0] hsPowerReq,
  input wire logic [NUM_PORTS-1:0] ssPowerReq,
  input wire logic [FILT_W-1:0] ocFiltLen,
  input wire logic [NUM_PORTS-1:0] portPinIn,
  input wire dpp_pkg::dpp_pin_t [NUM_PORTS-1:0] portPinCtl,
  input wire dpp_pkg::dpp_pin_t [NUM_PORTS-1:0] ssPinCtl,
  input wire logic [NUM_PORTS-1:0] hsOverCurrent,
  input wire logic [NUM_PORTS-1:0] chargeIndicate,
  input wire logic [NUM_PORTS-1:0] separatedActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [7:0] run_q, run_d;
    // saturating run of low samples, so a long fault cannot wrap
    always_comb run_d = portPinIn[p] ? 8'h00 : run_q + 8'(run_q != 8'hff);
    always_ff @(posedge clk_sys) run_q <= rst_b ? run_d : 8'h00;
    drive_low_a: assert property (
      !portPinCtl[p].outEnB |-> portPinCtl[p] == 3'h0) else $error("bad low");
    pull_release_a: assert property (
      portPinCtl[p].pullUpEn |-> portPinCtl[p].outEnB) else $error("pull");
    power_cause_a: assert property ($rose(portPinCtl[p].pullUpEn)
      |-> $past(hsPowerReq[p] | ssPowerReq[p])) else $error("no req");
    off_cause_a: assert property (
      !portPinCtl[p].outEnB |-> $past(!hsPowerReq[p])) else $error("off");
    ss_idle_a: assert property (!separatedActive[p]
      && !$past(separatedActive[p]) |-> ssPinCtl[p].outEnB
      && !ssPinCtl[p].pullUpEn) else $error("ss pin active");
    filt_min_a: assert property ($rose(hsOverCurrent[p])
      && ocFiltLen != '0 |-> $past(run_q, 3) >= 8'(ocFiltLen) - 8'h01)
      else $error("short low");
    charge_cause_a: assert property (
      $rose(chargeIndicate[p]) |-> $past(cfgLoad)) else $error("charge");
    split_cause_a: assert property (
      $changed(separatedActive[p]) |-> $past(cfgLoad)) else $error("split");
  end
  cover property ($rose(hsOverCurrent[0]));
  cover property ($rose(ssPinCtl[2].pullUpEn));
  cover property ($rose(chargeIndicate[1]));
endmodule // dpp_port_power_checker
bind dpp_port_power dpp_port_power_checker #(
  .NUM_PORTS(NUM_PORTS), .FILT_W(FILT_W)
) dpp_port_power_checker_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .cfgLoad(cfgLoad), .hsPowerReq(hsPowerReq), .ssPowerReq(ssPowerReq),
  .ocFiltLen(ocFiltLen), .portPinIn(portPinIn), .portPinCtl(portPinCtl),
  .ssPinCtl(ssPinCtl), .hsOverCurrent(hsOverCurrent),
  .chargeIndicate(chargeIndicate), .separatedActive(separatedActive));

// ==== tb_dpp_port_power.sv ====
// testbench: self-checking run of port power control
`timescale 1ns/10ps
module tb_dpp_port_power;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cfgLoad = 1'b0;
  dpp_pkg::dpp_cfg_t [3:0] portCfg = 12'h000;
  logic [3:0] hsPowerReq = 4'h0, ssPowerReq = 4'h0;
  logic [3:0] portFault = 4'h0, ssFault = 4'h0;
  logic [3:0] portPinIn, ssPinIn, hsOverCurrent, ssOverCurrent;
  logic [3:0] chargeIndicate, separatedActive;
  logic [7:0] ocFiltLen = 8'h04;
  dpp_pkg::dpp_pin_t [3:0] portPinCtl, ssPinCtl;
  int miscompares = 0;
  int checks = 0;
  initial forever #50 clk_sys = ~clk_sys;
  // short filter length keeps the fault runs brief
  dpp_port_power #(.NUM_PORTS(4), .FILT_W(8)) dpp_port_power_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .portCfg(portCfg), .cfgLoad(cfgLoad),
    .hsPowerReq(hsPowerReq), .ssPowerReq(ssPowerReq), .ocFiltLen(ocFiltLen),
    .portPinIn(portPinIn), .ssPinIn(ssPinIn), .portPinCtl(portPinCtl),
    .ssPinCtl(ssPinCtl), .hsOverCurrent(hsOverCurrent),
    .ssOverCurrent(ssOverCurrent), .chargeIndicate(chargeIndicate),
    .separatedActive(separatedActive));
  dpp_switch_model dpp_switch_model_i (.clk_sys(clk_sys),
    .pinCtl({ssPinCtl, portPinCtl}), .fault({ssFault, portFault}),
    .pinIn({ssPinIn, portPinIn}));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [7:0] pe(input dpp_pkg::dpp_pin_t c);
    return {6'h00, c.pullUpEn, c.outEnB};
  endfunction
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_oc();
    int i;
    for (i = 0; i < 50 && (hsOverCurrent | ssOverCurrent) === 4'h0; i++)
      @(posedge clk_sys);
    if (i == 50) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic t_unsel();
    check({4'h0, separatedActive}, 8'h00);
    hsPowerReq <= 4'hf;
    cyc(3);
    check(pe(portPinCtl[0]), 8'h01);
    check({hsOverCurrent, chargeIndicate}, 8'h00);
    $display("unsel done");
  endtask
  task automatic t_power();
    cfgLoad <= 1'b1;
    portCfg <= {3'h5, 3'h4, 3'h5, 3'h4};
    cyc(1);
    cfgLoad <= 1'b0;
    hsPowerReq <= 4'h5;
    ssPowerReq <= 4'h3;
    cyc(3);
    check(pe(portPinCtl[0]), 8'h03);
    check(pe(portPinCtl[1]), 8'h03);
    check(8'(portPinCtl[3]), 8'h00);
    check({4'h0, chargeIndicate}, 8'h0a);
    $display("power done");
  endtask
  task automatic t_filter();
    portFault <= 4'h1;
    cyc(2);
    portFault <= 4'h0;
    cyc(12);
    check({4'h0, hsOverCurrent}, 8'h00);
    portFault <= 4'h1;
    wait_oc();
    cyc(2);
    check({hsOverCurrent, ssOverCurrent}, 8'h11);
    portFault <= 4'h0;
    hsPowerReq <= 4'h4;
    ssPowerReq <= 4'h2;
    cyc(3);
    check({hsOverCurrent, ssOverCurrent}, 8'h11);
    hsPowerReq <= 4'h5;
    ssPowerReq <= 4'h3;
    cyc(4);
    check({hsOverCurrent, ssOverCurrent}, 8'h00);
    $display("filter done");
  endtask
  task automatic t_split();
    cfgLoad <= 1'b1;
    portCfg[2] <= 3'h6;
    hsPowerReq <= 4'h1;
    ssPowerReq <= 4'h5;
    cyc(1);
    cfgLoad <= 1'b0;
    cyc(3);
    check({4'h0, separatedActive}, 8'h04);
    check(8'(portPinCtl[2]), 8'h00);
    check(pe(ssPinCtl[2]), 8'h03);
    ssFault <= 4'h4;
    wait_oc();
    cyc(2);
    check({hsOverCurrent, ssOverCurrent}, 8'h04);
    $display("split done");
  endtask
  task automatic t_deflen();
    // zero length falls back to the 100-cycle default, far past 60
    ocFiltLen <= 8'h00;
    portFault <= 4'h1;
    cyc(60);
    check({hsOverCurrent, ssOverCurrent}, 8'h04);
    cyc(50);
    check({hsOverCurrent, ssOverCurrent}, 8'h15);
    $display("deflen done");
  endtask
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    t_unsel();
    t_power();
    t_filter();
    t_split();
    t_deflen();
    wrap_up();
  end
endmodule // tb_dpp_port_power
